/* File: core/uart_status_ctrl.sv */
// Modem status, FIFO control and interrupt identification of one UART.
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "uart_stat_map.svh"
module uart_status_ctrl
	import uart_stat_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic carrier_present_n_i,
	input wire logic incoming_call_n_i,
	input wire logic peer_ready_n_i,
	input wire logic send_clear_n_i,
	input wire logic overrun_i,
	input wire logic parity_fail_i,
	input wire logic framing_fail_i,
	input wire logic break_seen_i,
	input wire logic [4:0] rx_count_i,
	input wire logic rx_read_i,
	input wire logic tx_empty_i,
	input wire logic tx_write_i,
	input wire logic char_tick_i,
	output logic tx_fifo_reset_o,
	output logic rx_fifo_reset_o,
	output logic fifo_enable_o,
	output logic dma_mode_o,
	output logic [4:0] rx_trigger_o,
	output logic loopback_o,
	output logic irq_o,
	output logic irq_oe_o
);
	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic access_done;
	logic wr;
	logic rd;
	logic [7:0] modem_control_reg;
	logic [7:0] fifo_control_reg;
	logic [7:0] interrupt_enable_reg;
	logic [3:0] line_events;
	logic [3:0] change_flags;
	logic [3:0] modem_level;
	logic [7:0] modem_status_reg;
	logic [7:0] interrupt_ident_reg;
	logic [7:0] read_byte;
	logic [2:0] idle_chars;
	logic timeout_pend;
	logic tx_empty_flag;
	logic tx_empty_q;
	irq_src_t src;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		hit = (a == r);
	endfunction

	// Each access takes exactly one wait cycle: waitrequest drops on the first edge.
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			access_done <= 1'b0;
		else
			access_done <= (avs_read_i | avs_write_i) & ~access_done;
	end

	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~access_done;
	assign wr = avs_write_i & access_done & avs_byteenable_i[0];
	assign rd = avs_read_i & access_done;

	// ------------------------------------------------------------
	// Writable registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			modem_control_reg <= `RST_BYTE;
		else if (wr && hit(avs_address_i, `ADDR_MODEM_CONTROL))
			modem_control_reg <= {3'h0, avs_writedata_i[4:0]};
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			interrupt_enable_reg <= `RST_BYTE;
		else if (wr && hit(avs_address_i, `ADDR_INT_ENABLE))
			interrupt_enable_reg <= {4'h0, avs_writedata_i[3:0]};
	end

	// Reset strobes live in the register for one cycle only, then self-clear.
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			fifo_control_reg <= `RST_BYTE;
		else if (wr && hit(avs_address_i, `ADDR_FIFO_CONTROL))
		begin
			fifo_control_reg[`FCR_FIFO_EN] <= avs_writedata_i[0];
			fifo_control_reg[`FCR_RX_RESET] <= avs_writedata_i[1];
			fifo_control_reg[`FCR_TX_RESET] <= avs_writedata_i[2];
			// DMA mode 1 needs FIFO mode in the same write.
			fifo_control_reg[`FCR_DMA_MODE] <= avs_writedata_i[3] & avs_writedata_i[0];
			fifo_control_reg[5:4] <= 2'h0;
			fifo_control_reg[`FCR_TRIG_HI:`FCR_TRIG_LO] <= avs_writedata_i[7:6];
		end
		else
		begin
			fifo_control_reg[`FCR_RX_RESET] <= 1'b0;
			fifo_control_reg[`FCR_TX_RESET] <= 1'b0;
		end
	end

	assign fifo_enable_o = fifo_control_reg[`FCR_FIFO_EN];
	assign tx_fifo_reset_o = fifo_control_reg[`FCR_TX_RESET];
	assign rx_fifo_reset_o = fifo_control_reg[`FCR_RX_RESET];
	assign dma_mode_o = fifo_control_reg[`FCR_DMA_MODE];
	assign loopback_o = modem_control_reg[`MCR_LOOPBACK];

	always_comb
	begin
		unique case (fifo_control_reg[`FCR_TRIG_HI:`FCR_TRIG_LO])
			2'h0: rx_trigger_o = `TRIG_LEVEL_0;
			2'h1: rx_trigger_o = `TRIG_LEVEL_1;
			2'h2: rx_trigger_o = `TRIG_LEVEL_2;
			2'h3: rx_trigger_o = `TRIG_LEVEL_3;
		endcase
	end

	// ------------------------------------------------------------
	// Modem status
	// ------------------------------------------------------------
	modem_change_detect u_modem
	(
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.pins_n_i({carrier_present_n_i, incoming_call_n_i, peer_ready_n_i, send_clear_n_i}),
		.loopback_i(modem_control_reg[`MCR_LOOPBACK]),
		.loop_src_i({modem_control_reg[`MCR_IRQ_OUT_EN], modem_control_reg[`MCR_LOOP_CALL],
			modem_control_reg[`MCR_PEER_READY], modem_control_reg[`MCR_SEND_REQ]}),
		.clear_i(rd && hit(avs_address_i, `ADDR_MODEM_STATUS)),
		.level_o(modem_level),
		.flags_o(change_flags)
	);

	assign modem_status_reg = {modem_level, change_flags};

	// ------------------------------------------------------------
	// Interrupt sources
	// ------------------------------------------------------------
	// Line error events are sticky; a new error beats the clearing read.
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			line_events <= 4'h0;
		else
			line_events <= ((rd && hit(avs_address_i, `ADDR_LINE_EVENTS)) ? 4'h0 : line_events)
				| {break_seen_i, framing_fail_i, parity_fail_i, overrun_i};
	end

	// Character-time counter restarts on every receive access or when empty.
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			idle_chars <= 3'h0;
		else if (rx_read_i || rx_count_i == 5'h00 || !fifo_control_reg[`FCR_FIFO_EN])
			idle_chars <= 3'h0;
		else if (char_tick_i && idle_chars != `TIMEOUT_CHARS)
			idle_chars <= idle_chars + 3'h1;
	end

	assign timeout_pend = (idle_chars == `TIMEOUT_CHARS);

	// Transmit empty is re-armed on its rising edge, dropped by a holding write or
	// by an ident read that showed it.
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			tx_empty_q <= 1'b0;
			tx_empty_flag <= 1'b0;
		end
		else
		begin
			tx_empty_q <= tx_empty_i;
			if (tx_empty_i && !tx_empty_q)
				tx_empty_flag <= 1'b1;
			else if (tx_write_i || (rd && hit(avs_address_i, `ADDR_INT_IDENT)
				&& src == SRC_TX_EMPTY))
				tx_empty_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Priority encoder
	// ------------------------------------------------------------
	always_comb
	begin
		src = SRC_NONE;
		if (interrupt_enable_reg[`IER_LINE] && line_events != 4'h0)
			src = SRC_LINE;
		else if (interrupt_enable_reg[`IER_RX_READY] && fifo_control_reg[`FCR_FIFO_EN]
			&& timeout_pend)
			src = SRC_TIMEOUT;
		else if (interrupt_enable_reg[`IER_RX_READY] && (fifo_control_reg[`FCR_FIFO_EN]
			? rx_count_i >= rx_trigger_o : rx_count_i != 5'h00))
			src = SRC_RX_DATA;
		else if (interrupt_enable_reg[`IER_TX_EMPTY] && tx_empty_flag)
			src = SRC_TX_EMPTY;
		else if (interrupt_enable_reg[`IER_HANDSHAKE] && change_flags != 4'h0)
			src = SRC_HANDSHAKE;
	end

	always_comb
	begin
		interrupt_ident_reg = 8'h00;
		if (fifo_control_reg[`FCR_FIFO_EN])
			interrupt_ident_reg[7:6] = `FIFO_ON_BITS;
		unique case (src)
			SRC_NONE: interrupt_ident_reg[3:0] = `CODE_NONE;
			SRC_LINE: interrupt_ident_reg[3:0] = `CODE_LINE;
			SRC_RX_DATA: interrupt_ident_reg[3:0] = `CODE_RX_DATA;
			SRC_TIMEOUT: interrupt_ident_reg[3:0] = `CODE_TIMEOUT;
			SRC_TX_EMPTY: interrupt_ident_reg[3:0] = `CODE_TX_EMPTY;
			SRC_HANDSHAKE: interrupt_ident_reg[3:0] = `CODE_HANDSHAKE;
		endcase
	end

	// The pin is released rather than driven low while output is disabled.
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			irq_o <= 1'b0;
			irq_oe_o <= 1'b0;
		end
		else
		begin
			irq_o <= (src != SRC_NONE);
			irq_oe_o <= modem_control_reg[`MCR_IRQ_OUT_EN];
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_comb
	begin
		read_byte = 8'h00;
		unique case (avs_address_i)
			`ADDR_MODEM_STATUS: read_byte = modem_status_reg;
			`ADDR_FIFO_CONTROL: read_byte = fifo_control_reg;
			`ADDR_INT_IDENT: read_byte = interrupt_ident_reg;
			`ADDR_MODEM_CONTROL: read_byte = modem_control_reg;
			`ADDR_INT_ENABLE: read_byte = interrupt_enable_reg;
			`ADDR_LINE_EVENTS: read_byte = {4'h0, line_events};
			`ADDR_LOOSE_STATUS: read_byte = {3'h0, tx_empty_flag, timeout_pend,
				fifo_control_reg[`FCR_DMA_MODE], loopback_o, irq_o};
			default: read_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			avs_readdata_o <= 32'h0000_0000;
		else if (avs_read_i && !access_done)
			avs_readdata_o <= {24'h00_0000, read_byte};
	end
endmodule

/* File: shared/uart_stat_map.svh */
// Register offsets, field positions, reset values and codes of the UART status block.
`ifndef UART_STAT_MAP_SVH
`define UART_STAT_MAP_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_MODEM_STATUS 4'h0
`define ADDR_FIFO_CONTROL 4'h4
`define ADDR_INT_IDENT 4'h8
`define ADDR_MODEM_CONTROL 4'hC
`define ADDR_INT_ENABLE 4'h1
`define ADDR_LINE_EVENTS 4'h2
`define ADDR_LOOSE_STATUS 4'h3
`define ADDR_BITS 4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MCR_PEER_READY 0
`define MCR_SEND_REQ 1
`define MCR_LOOP_CALL 2
`define MCR_IRQ_OUT_EN 3
`define MCR_LOOPBACK 4
`define FCR_FIFO_EN 0
`define FCR_RX_RESET 1
`define FCR_TX_RESET 2
`define FCR_DMA_MODE 3
`define FCR_TRIG_LO 6
`define FCR_TRIG_HI 7
`define IER_RX_READY 0
`define IER_TX_EMPTY 1
`define IER_LINE 2
`define IER_HANDSHAKE 3

// ----------------------------------------------------------------
// Reset values, trigger levels and identification codes
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define TRIG_LEVEL_0 5'h01
`define TRIG_LEVEL_1 5'h04
`define TRIG_LEVEL_2 5'h08
`define TRIG_LEVEL_3 5'h0E
`define CODE_NONE 4'h1
`define CODE_LINE 4'h6
`define CODE_RX_DATA 4'h4
`define CODE_TIMEOUT 4'hC
`define CODE_TX_EMPTY 4'h2
`define CODE_HANDSHAKE 4'h0
`define FIFO_ON_BITS 2'h3
`define TIMEOUT_CHARS 3'h4

`endif

/* File: shared/uart_stat_pkg.sv */
// Types shared by the UART status block.
package uart_stat_pkg;
	typedef enum logic [5:0] {
		SRC_NONE = 6'h01,
		SRC_LINE = 6'h02,
		SRC_RX_DATA = 6'h04,
		SRC_TIMEOUT = 6'h08,
		SRC_TX_EMPTY = 6'h10,
		SRC_HANDSHAKE = 6'h20
	} irq_src_t;
endpackage

/* File: core/modem_change_detect.sv */
// Synchronises the four modem input pins and keeps their sticky change flags.
`timescale 1ns/1ps
module modem_change_detect
	import uart_stat_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] pins_n_i,
	input wire logic loopback_i,
	input wire logic [3:0] loop_src_i,
	input wire logic clear_i,
	output logic [3:0] level_o,
	output logic [3:0] flags_o
);
	// Order of every vector: [3] carrier, [2] call, [1] peer ready, [0] clear to send.
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic [3:0] level_q;
	logic [3:0] level;
	logic [3:0] change;

	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			sync_a <= 4'hF;
			sync_b <= 4'hF;
		end
		else
		begin
			sync_a <= pins_n_i;
			sync_b <= sync_a;
		end
	end

	// Loopback swaps the source, so the flags also see loopback-driven changes.
	assign level = loopback_i ? loop_src_i : ~sync_b;

	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			level_q <= 4'h0;
		else
			level_q <= level;
	end

	// The call flag wants the pin going high, i.e. the inverted level falling.
	assign change = {level[3] ^ level_q[3],
		~level[2] & level_q[2],
		level[1:0] ^ level_q[1:0]};

	// A change in the same cycle as the read survives it.
	always_ff @(posedge clk_sys_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			flags_o <= 4'h0;
		else
			flags_o <= (clear_i ? 4'h0 : flags_o) | change;
	end

	assign level_o = level_q;
endmodule

/* File: verif/modem_peer.sv */
// Modem peer model driving the four active-low handshake pins.
`timescale 1ns/1ps
module modem_peer
(
	input wire logic clk_sys_i,
	input wire logic [3:0] want_i,
	output logic [3:0] pins_n_o
);
	// Pins idle high; an asserted line is pulled low just after an edge.
	initial pins_n_o = 4'hF;
	always @(posedge clk_sys_i)
		pins_n_o <= ~want_i;
endmodule

/* File: verif/uart_status_ctrl_assertions.sv */
// Port-level checks of the UART status block.
`timescale 1ns/1ps
`include "uart_stat_map.svh"
module uart_status_ctrl_assertions
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic tx_fifo_reset_o,
	input wire logic rx_fifo_reset_o,
	input wire logic fifo_enable_o,
	input wire logic dma_mode_o,
	input wire logic [4:0] rx_trigger_o
);
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);
	function automatic logic [4:0] lvl(input logic [1:0] s);
		return (s == 2'h0) ? `TRIG_LEVEL_0 : (s == 2'h1) ? `TRIG_LEVEL_1 :
			(s == 2'h2) ? `TRIG_LEVEL_2 : `TRIG_LEVEL_3;
	endfunction
	sequence s_fcr;
		avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] &&
			avs_address_i == `ADDR_FIFO_CONTROL;
	endsequence
	sequence s_ident;
		avs_read_i && !avs_waitrequest_o && avs_address_i == `ADDR_INT_IDENT;
	endsequence
	a_tx_reset_pulse: assert property (s_fcr ##0 avs_writedata_i[2]
		|=> tx_fifo_reset_o ##1 !tx_fifo_reset_o) else $error("tx reset pulse wrong");
	a_rx_reset_pulse: assert property (s_fcr ##0 avs_writedata_i[1]
		|=> rx_fifo_reset_o ##1 !rx_fifo_reset_o) else $error("rx reset pulse wrong");
	a_fifo_enable_follows: assert property (s_fcr
		|=> fifo_enable_o == $past(avs_writedata_i[0])) else $error("fifo enable wrong");
	a_dma_needs_fifo: assert property ($rose(dma_mode_o) |-> fifo_enable_o)
		else $error("dma mode without fifo");
	a_trigger_level: assert property (s_fcr ##0 avs_writedata_i[0]
		|=> rx_trigger_o == lvl($past(avs_writedata_i[7:6]))) else $error("bad trigger");
	a_ident_fifo_bits: assert property (s_ident
		|-> avs_readdata_o[7:4] == {fifo_enable_o, fifo_enable_o, 2'h0})
		else $error("ident high bits wrong");
	a_ident_bit3_off: assert property (s_ident ##0 !fifo_enable_o
		|-> !avs_readdata_o[3]) else $error("ident bit 3 set without fifo");
	a_idle_code: assert property (s_ident ##0 avs_readdata_o[0]
		|-> avs_readdata_o[3:1] == 3'h0) else $error("idle code wrong");
endmodule
bind uart_status_ctrl uart_status_ctrl_assertions uart_status_ctrl_assertions_inst (
	.clk_sys_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
	.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .tx_fifo_reset_o,
	.rx_fifo_reset_o, .fifo_enable_o, .dma_mode_o, .rx_trigger_o);

/* File: verif/test_uart_modem_fifo_irq_status.sv */
// Self-checking bench of the UART status block with a modem peer.
`timescale 1ns/1ps
`include "uart_stat_map.svh"
module test_uart_modem_fifo_irq_status;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] avs_address_i = 4'h0;
	logic [3:0] avs_byteenable_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [3:0] pins_n;
	logic [3:0] want = 4'h0;
	logic [3:0] lerr = 4'h0;
	logic rx_read_i = 1'b0, tx_empty_i = 1'b0, tx_write_i = 1'b0, char_tick_i = 1'b0;
	logic [4:0] rx_count_i = 5'h00;
	logic tx_fifo_reset_o, rx_fifo_reset_o, fifo_enable_o, dma_mode_o, loopback_o;
	logic irq_o, irq_oe_o;
	logic [4:0] rx_trigger_o;
	int err_total = 0;
	int check_count = 0;
	logic [15:0] rnd = 16'hD599;
	logic [31:0] d;
	logic [3:0] prev = 4'h0;
	logic [3:0] cur;
	modem_peer modem_peer_inst (.clk_sys_i, .want_i(want), .pins_n_o(pins_n));
	uart_status_ctrl uart_status_ctrl_inst (.clk_sys_i, .sys_rst_i, .avs_address_i,
		.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
		.avs_waitrequest_o, .carrier_present_n_i(pins_n[3]), .incoming_call_n_i(pins_n[2]),
		.peer_ready_n_i(pins_n[1]), .send_clear_n_i(pins_n[0]), .overrun_i(lerr[0]),
		.parity_fail_i(lerr[1]), .framing_fail_i(lerr[2]), .break_seen_i(lerr[3]),
		.rx_count_i, .rx_read_i, .tx_empty_i, .tx_write_i, .char_tick_i, .tx_fifo_reset_o,
		.rx_fifo_reset_o, .fifo_enable_o, .dma_mode_o, .rx_trigger_o, .loopback_o, .irq_o,
		.irq_oe_o);
	initial
	begin
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [31:0] stat_exp(input logic [3:0] p, input logic [3:0] c);
		return {24'h0, c, c[3] ^ p[3], p[2] & !c[2], c[1] ^ p[1], c[0] ^ p[0]};
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v,
		input logic [3:0] b);
		int n;
		n = 0;
		avs_read_i <= !w;
		avs_write_i <= w;
		avs_address_i <= a;
		avs_writedata_i <= {24'h0, v};
		avs_byteenable_i <= b;
		do
		begin
			@(posedge clk_sys_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0 && n < 40);
		d = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_sys_i);
		if (n >= 40)
		begin
			err_total++;
			tally_and_finish();
		end
	endtask
	task automatic wr8(input logic [3:0] a, input logic [7:0] v);
		bus(1'b1, a, v, 4'hF);
	endtask
	task automatic rd_chk(input string n, input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00, 4'hF);
		check(n, d, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	initial
	begin
		cyc(2);
		sys_rst_i <= 1'b0;
		cyc(1);
		rd_chk("status idle", `ADDR_MODEM_STATUS, 32'h0);
		for (int i = 0; i < 12; i++)
		begin
			rnd = lfsr(rnd);
			cur = (i == 0) ? 4'hF : rnd[3:0];
			want <= cur;
			cyc(5);
			rd_chk("status", `ADDR_MODEM_STATUS, stat_exp(prev, cur));
			rd_chk("status reread", `ADDR_MODEM_STATUS, {24'h0, cur, 4'h0});
			prev = cur;
		end
		want <= 4'h0;
		for (int v = 0; v < 16; v++)
		begin
			wr8(`ADDR_MODEM_CONTROL, 8'h10 | v[7:0]);
			cyc(4);
			bus(1'b0, `ADDR_MODEM_STATUS, 8'h00, 4'hF);
			check("loop status", {28'h0, d[7:4]}, {28'h0, v[3], v[2], v[0], v[1]});
			check("irq pin enable", irq_oe_o, v[3]);
			check("loopback out", loopback_o, 1'b1);
		end
		wr8(`ADDR_MODEM_CONTROL, 8'h08);
		cyc(5);
		bus(1'b0, `ADDR_MODEM_STATUS, 8'h00, 4'hF);
		wr8(`ADDR_FIFO_CONTROL, 8'h08);
		check("dma off", dma_mode_o, 1'b0);
		rd_chk("ident no fifo", `ADDR_INT_IDENT, 32'h01);
		for (int t = 0; t < 4; t++)
		begin
			wr8(`ADDR_FIFO_CONTROL, {t[1:0], 6'h01});
			check("trigger", rx_trigger_o, t == 0 ? 1 : t == 1 ? 4 : t == 2 ? 8 : 14);
			rd_chk("ident fifo", `ADDR_INT_IDENT, 32'hC1);
		end
		bus(1'b1, `ADDR_FIFO_CONTROL, 8'h00, 4'h0);
		check("masked write", fifo_enable_o, 1'b1);
		wr8(`ADDR_FIFO_CONTROL, 8'h0F);
		check("dma on", dma_mode_o, 1'b1);
		wr8(`ADDR_FIFO_CONTROL, 8'h01);
		lerr <= 4'h1;
		cyc(1);
		lerr <= 4'h0;
		cyc(3);
		rd_chk("ident masked", `ADDR_INT_IDENT, 32'hC1);
		check("irq masked", irq_o, 1'b0);
		bus(1'b0, `ADDR_LINE_EVENTS, 8'h00, 4'hF);
		wr8(`ADDR_INT_ENABLE, 8'h0F);
		for (int k = 0; k < 4; k++)
		begin
			lerr <= 4'h1 << k;
			tx_empty_i <= (k == 3);
			rx_count_i <= (k == 3) ? 5'h01 : 5'h00;
			cyc(1);
			lerr <= 4'h0;
			cyc(3);
			rd_chk("ident line", `ADDR_INT_IDENT, 32'hC6);
			check("irq pin", irq_o, 1'b1);
			bus(1'b0, `ADDR_LINE_EVENTS, 8'h00, 4'hF);
		end
		rd_chk("ident data", `ADDR_INT_IDENT, 32'hC4);
		rx_count_i <= 5'h00;
		cyc(3);
		rd_chk("ident tx", `ADDR_INT_IDENT, 32'hC2);
		rd_chk("ident tx read", `ADDR_INT_IDENT, 32'hC1);
		tx_empty_i <= 1'b0;
		cyc(2);
		tx_empty_i <= 1'b1;
		cyc(3);
		tx_write_i <= 1'b1;
		cyc(1);
		tx_write_i <= 1'b0;
		cyc(3);
		rd_chk("ident tx write", `ADDR_INT_IDENT, 32'hC1);
		want <= 4'h2;
		cyc(5);
		rd_chk("ident modem", `ADDR_INT_IDENT, 32'hC0);
		bus(1'b0, `ADDR_MODEM_STATUS, 8'h00, 4'hF);
		rd_chk("ident modem read", `ADDR_INT_IDENT, 32'hC1);
		wr8(`ADDR_FIFO_CONTROL, 8'h41);
		rx_count_i <= 5'h01;
		for (int k = 1; k < 5; k++)
		begin
			char_tick_i <= 1'b1;
			cyc(1);
			char_tick_i <= 1'b0;
			cyc(3);
			rd_chk("ident timeout", `ADDR_INT_IDENT, k == 4 ? 32'hCC : 32'hC1);
		end
		rx_read_i <= 1'b1;
		cyc(1);
		rx_read_i <= 1'b0;
		cyc(3);
		rd_chk("ident after read", `ADDR_INT_IDENT, 32'hC1);
		wr8(`ADDR_FIFO_CONTROL, 8'h00);
		cyc(3);
		rd_chk("ident plain data", `ADDR_INT_IDENT, 32'h04);
		rd_chk("unmapped", 4'hF, 32'h0);
		wr8(`ADDR_MODEM_CONTROL, 8'h00);
		// The enable flop follows the control register one edge after the write lands.
		cyc(1);
		check("irq pin off", irq_oe_o, 1'b0);
		tally_and_finish();
	end
endmodule
